/* File: logic/tsi_conn_pkg.sv */
// Constants, register map and field layout of the connection word slot engine.
// Assumes an AXI4-Lite master on the register side and one system clock.
// Notes on behaviour
// (R1) Input offset is 0 to 4.5 periods in half steps: count plus edge bit. The 4-bit field is not limited and reaches 7.5 periods.
// (R2) Measurement reads half flag 1 for whole shifts, count is the whole part.
// (R3) Connection words are 16 bits; bit 15 loops transmitted data back to receive.
// (R4) Software keeps the offset of looped-back streams at zero.
// (R5) Bit 14 picks variable (0) or constant (1) delay per channel.
// (R6) Bit 13 set sends the word's low byte out instead of switched data.
// (R7) Bit 13 clear makes stream and channel fields the source address.
// (R8) Bit 12 goes out on the control pin one channel early, stream 0 first.
// (R9) Bit 11 high drives the transmit output; low holds it in high impedance.
// (R10) Bits 10 to 7 carry the source stream number.
// (R11) Bits 6 to 0 carry the source channel number.
// (R12) Only 5, 6 or 7 channel bits are used for 32, 64 or 128 channels.
// (R13) The offset field sets the wait after the frame pulse before bit 0.
// (R14) Default interface: edge bit 0 means rising edge at three quarter point.
// (R15) Alternate interface: edge bit 0 means falling edge at three quarter point.
// (R16) Each of 16 input streams has its own offset field and edge bit.
// (R17) One connection word is read per output stream and channel each slot.
package tsi_conn_pkg;
	localparam int ADDR_W = 14;
	localparam logic [13:0] CTRL_OFS = 14'h0000;
	localparam logic [13:0] OFS_REG0_OFS = 14'h0004;
	localparam logic [13:0] OFS_REG3_OFS = 14'h0010;
	localparam logic [13:0] MEAS_OFS = 14'h0014;
	localparam logic [13:0] STAT_OFS = 14'h0018;
	localparam int CM_SEL_BIT = 13;
	localparam int STREAMS_PER_OFS_REG = 4;
	localparam int OFS_FIELD_W = 4;
	localparam int LOOP_BACK_BIT_BIT = 15;
	localparam int VC_BIT = 14;
	localparam int PC_BIT = 13;
	localparam int CCO_BIT = 12;
	localparam int OE_BIT = 11;
	localparam int SRC_STREAM_LSB = 7;
	localparam int SRC_STREAM_W = 4;
	localparam int SRC_CHAN_W = 7;
	localparam int PC_BYTE_W = 8;
	localparam int WORD_W = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RATE_32 = 2'h0;
	localparam logic [1:0] RATE_64 = 2'h1;
	localparam logic [6:0] MASK_32 = 7'h1f;
	localparam logic [6:0] MASK_64 = 7'h3f;
	localparam logic [6:0] MASK_128 = 7'h7f;
	localparam logic [15:0] CM_RESET = 16'h0000;
	localparam logic [3:0] OFS_RESET = 4'h0;
	localparam logic [1:0] RATE_RESET = 2'h2;
endpackage

/* File: logic/tsi_skid_buf.sv */
// Two-entry valid/ready buffer; both output data and valid come from flip-flops.
// Assumes a single clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module tsi_skid_buf #(
	parameter int WIDTH = 8
) (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	logic skid_valid_r;
	logic [WIDTH-1:0] skid_data_r;
	logic in_take;
	logic out_take;

	assign o_in_ready = ~skid_valid_r;
	assign in_take = i_in_valid & ~skid_valid_r;
	assign out_take = o_out_valid & i_out_ready;

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_out_valid <= 1'b0;
			o_out_data <= '0;
		end else if (!o_out_valid || out_take) begin
			o_out_valid <= skid_valid_r | in_take;
			o_out_data <= skid_valid_r ? skid_data_r : i_in_data;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			skid_valid_r <= 1'b0;
			skid_data_r <= '0;
		end else if (skid_valid_r) begin
			if (!o_out_valid || out_take) begin
				skid_valid_r <= 1'b0;
			end
		end else if (in_take && o_out_valid && !i_out_ready) begin
			skid_valid_r <= 1'b1;
			skid_data_r <= i_in_data;
		end
	end
endmodule // tsi_skid_buf

/* File: logic/tsi_conn_engine.sv */
// Connection word store, per-stream offset control and output slot engine.
// Assumes an AXI4-Lite master and a frame pulse synchronous to i_sys_clk.
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module tsi_conn_engine
	import tsi_conn_pkg::*;
#(
	parameter int N_STREAMS = 16,
	parameter int N_CHAN = 128
) (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [ADDR_W-1:0] i_awaddr,
	input wire logic i_wvalid,
	output logic o_wready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	output logic o_bvalid,
	input wire logic i_bready,
	output logic [1:0] o_bresp,
	input wire logic i_arvalid,
	output logic o_arready,
	input wire logic [ADDR_W-1:0] i_araddr,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	input wire logic i_frame_pulse_in,
	input wire logic i_gci_mode,
	input wire logic i_meas_valid,
	input wire logic [3:0] i_meas_half_delay,
	output logic [N_STREAMS*4-1:0] o_in_delay_half,
	output logic [N_STREAMS-1:0] o_latch_on_rise,
	output logic o_control_channel_out,
	output logic o_slot_valid,
	input wire logic i_slot_ready,
	output logic [SRC_STREAM_W-1:0] o_slot_stream,
	output logic [SRC_CHAN_W-1:0] o_slot_chan,
	output logic o_loop_back_bit,
	output logic o_const_delay,
	output logic o_processor_channel_bit,
	output logic o_tx_drive_en,
	output logic [SRC_STREAM_W-1:0] o_source_stream_field,
	output logic [SRC_CHAN_W-1:0] o_source_channel_field,
	output logic [PC_BYTE_W-1:0] o_pc_byte
);
	localparam int N_WORDS = N_STREAMS * N_CHAN;
	localparam int IDX_W = $clog2(N_WORDS);
	localparam int ITEM_W = 2 * SRC_STREAM_W + 2 * SRC_CHAN_W + PC_BYTE_W + 4;

	logic [WORD_W-1:0] cm_r [N_WORDS];
	logic [3:0] ofs_r [N_STREAMS];
	logic [1:0] rate_r;
	logic [3:0] meas_r;
	logic [SRC_STREAM_W-1:0] stream_r;
	logic [SRC_CHAN_W-1:0] chan_r;
	logic [SRC_CHAN_W-1:0] chan_nxt;
	logic [SRC_CHAN_W-1:0] chan_mask;
	logic aw_ready_r;
	logic ar_ready_r;
	logic wr_en;
	logic rd_en;
	logic wr_cm;
	logic [IDX_W-1:0] wr_idx;
	logic [IDX_W-1:0] rd_idx;
	logic [15:0] wr_bytes;
	logic [15:0] wr_mask;
	logic [31:0] rd_val;
	logic rd_ok;
	logic wr_ok;
	logic [WORD_W-1:0] cur_word;
	logic [WORD_W-1:0] next_word;
	logic [ITEM_W-1:0] item;
	logic [ITEM_W-1:0] item_out;
	logic buf_ready;
	logic last_chan;
	logic last_stream;

	assign o_awready = aw_ready_r;
	assign o_wready = aw_ready_r;
	assign o_arready = ar_ready_r;
	assign wr_en = aw_ready_r & i_awvalid & i_wvalid;
	assign rd_en = ar_ready_r & i_arvalid;
	assign wr_cm = i_awaddr[CM_SEL_BIT];
	assign wr_idx = i_awaddr[IDX_W+1:2];
	assign rd_idx = i_araddr[IDX_W+1:2];
	assign wr_bytes = i_wdata[15:0];
	assign wr_mask = {{8{i_wstrb[1]}}, {8{i_wstrb[0]}}};

	// Write channel: address and data are taken together, then one response.
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			aw_ready_r <= 1'b0;
			o_bvalid <= 1'b0;
			o_bresp <= RESP_OKAY;
		end else begin
			aw_ready_r <= i_awvalid & i_wvalid & ~aw_ready_r & ~o_bvalid;
			if (wr_en) begin
				o_bvalid <= 1'b1;
				o_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (i_bready) begin
				o_bvalid <= 1'b0;
			end
		end
	end

	always_comb begin
		wr_ok = wr_cm || (i_awaddr == CTRL_OFS) || (i_awaddr == MEAS_OFS)
			|| (i_awaddr == STAT_OFS)
			|| (i_awaddr >= OFS_REG0_OFS && i_awaddr <= OFS_REG3_OFS && i_awaddr[1:0] == 2'h0);
	end

	// Connection words, one flop entry each, with byte-lane writes.
	for (genvar w = 0; w < N_WORDS; w++) begin : g_cm
		always_ff @(posedge i_sys_clk or negedge i_rstn) begin
			if (!i_rstn) begin
				cm_r[w] <= CM_RESET;
			end else if (wr_en && wr_cm && wr_idx == IDX_W'(w)) begin
				cm_r[w] <= (cm_r[w] & ~wr_mask) | (wr_bytes & wr_mask); // [R3]
			end
		end
	end

	// Per-stream offset field and edge bit, four streams to a register.
	for (genvar s = 0; s < N_STREAMS; s++) begin : g_ofs
		localparam int LANE = (s % STREAMS_PER_OFS_REG) / 2;
		localparam int POS = (s % STREAMS_PER_OFS_REG) * OFS_FIELD_W;
		localparam logic [13:0] REG = OFS_REG0_OFS + 14'((s / STREAMS_PER_OFS_REG) * 4);
		always_ff @(posedge i_sys_clk or negedge i_rstn) begin
			if (!i_rstn) begin
				ofs_r[s] <= OFS_RESET; // [R1]
			end else if (wr_en && i_awaddr == REG && i_wstrb[LANE]) begin
				ofs_r[s] <= i_wdata[POS +: OFS_FIELD_W]; // [R16]
			end
		end
		// Wait after the frame pulse, in half periods: two per count plus the edge bit.
		always_ff @(posedge i_sys_clk or negedge i_rstn) begin
			if (!i_rstn) begin
				o_in_delay_half[s*4 +: 4] <= 4'h0;
				o_latch_on_rise[s] <= 1'b1;
			end else begin
				o_in_delay_half[s*4 +: 4] <= {ofs_r[s][3:1], ofs_r[s][0]}; // [R1] [R13]
				o_latch_on_rise[s] <= ~ofs_r[s][0] ^ i_gci_mode; // [R14] [R15]
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rate_r <= RATE_RESET;
		end else if (wr_en && i_awaddr == CTRL_OFS && i_wstrb[0]) begin
			rate_r <= i_wdata[1:0];
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			meas_r <= 4'h0;
		end else if (i_meas_valid) begin
			meas_r <= i_meas_half_delay;
		end
	end

	// Read channel: the answer is registered one cycle after the address is taken.
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_ok = 1'b1;
		if (i_araddr[CM_SEL_BIT]) begin
			rd_val = {16'h0000, cm_r[rd_idx]};
		end else if (i_araddr == CTRL_OFS) begin
			rd_val = {30'h0000_0000, rate_r};
		end else if (i_araddr == MEAS_OFS) begin
			rd_val = {28'h000_0000, ~meas_r[0], meas_r[3:1]}; // [R2]
		end else if (i_araddr == STAT_OFS) begin
			rd_val = {16'h0000, 1'b0, chan_r, 4'h0, stream_r};
		end else if (i_araddr >= OFS_REG0_OFS && i_araddr <= OFS_REG3_OFS
			&& i_araddr[1:0] == 2'h0) begin
			for (int k = 0; k < N_STREAMS; k++) begin
				if (i_araddr[13:2] == 12'((OFS_REG0_OFS >> 2) + k / STREAMS_PER_OFS_REG)) begin
					rd_val[(k % STREAMS_PER_OFS_REG) * OFS_FIELD_W +: OFS_FIELD_W] = ofs_r[k];
				end
			end
		end else begin
			rd_ok = 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ar_ready_r <= 1'b0;
			o_rvalid <= 1'b0;
			o_rdata <= 32'h0000_0000;
			o_rresp <= RESP_OKAY;
		end else begin
			ar_ready_r <= i_arvalid & ~ar_ready_r & ~o_rvalid;
			if (rd_en) begin
				o_rvalid <= 1'b1;
				o_rdata <= rd_val;
				o_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (i_rready) begin
				o_rvalid <= 1'b0;
			end
		end
	end

	// Channel count and source channel width follow the stream rate.
	always_comb begin
		unique case (rate_r)
			RATE_32: chan_mask = MASK_32; // [R12]
			RATE_64: chan_mask = MASK_64; // [R12]
			default: chan_mask = MASK_128; // [R12]
		endcase
	end

	assign last_chan = (chan_r == chan_mask);
	assign last_stream = (stream_r == SRC_STREAM_W'(N_STREAMS - 1));
	assign chan_nxt = last_chan ? '0 : chan_r + 1'b1;
	assign cur_word = cm_r[{stream_r, chan_r}]; // [R17]
	assign next_word = cm_r[{stream_r, chan_nxt}];

	// Slot scan: streams inside each channel, stream 0 first; frame pulse restarts.
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			stream_r <= '0;
			chan_r <= '0;
		end else if (i_frame_pulse_in) begin
			stream_r <= '0;
			chan_r <= '0;
		end else if (buf_ready) begin
			stream_r <= last_stream ? '0 : stream_r + 1'b1; // [R8] [R17]
			if (last_stream) begin
				chan_r <= chan_nxt;
			end
		end
	end

	// The control bit leaves one channel ahead of the slot it belongs to.
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_control_channel_out <= 1'b0;
		end else if (buf_ready && !i_frame_pulse_in) begin
			o_control_channel_out <= next_word[CCO_BIT]; // [R8]
		end
	end

	always_comb begin
		item = {stream_r, chan_r,
			cur_word[LOOP_BACK_BIT_BIT], // [R3]
			cur_word[VC_BIT], // [R5]
			cur_word[PC_BIT], // [R6] [R7]
			cur_word[OE_BIT], // [R9]
			cur_word[SRC_STREAM_LSB +: SRC_STREAM_W], // [R10] [R7]
			cur_word[SRC_CHAN_W-1:0] & chan_mask, // [R11] [R12]
			cur_word[PC_BYTE_W-1:0]}; // [R6]
	end

	tsi_skid_buf #(
		.WIDTH(ITEM_W)
	) u_slot_buf (
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.i_in_valid(~i_frame_pulse_in),
		.o_in_ready(buf_ready),
		.i_in_data(item),
		.o_out_valid(o_slot_valid),
		.i_out_ready(i_slot_ready),
		.o_out_data(item_out)
	);

	assign {o_slot_stream, o_slot_chan, o_loop_back_bit, o_const_delay,
		o_processor_channel_bit, o_tx_drive_en, o_source_stream_field,
		o_source_channel_field, o_pc_byte} = item_out;
endmodule // tsi_conn_engine

/* File: sim/tsi_conn_engine_assertions.sv */
// Concurrent checks on the ports of the connection engine.
// Assumes one clock and the asynchronous active-low reset of the engine.
`timescale 1ns/1ps
module tsi_conn_engine_assertions
	import tsi_conn_pkg::*;
#(
	parameter int N_STREAMS = 16
) (
	input wire logic i_sys_clk,
	i_rstn,
	i_awvalid,
	o_awready,
	i_wvalid,
	o_bvalid,
	i_bready,
	i_arvalid,
	o_arready,
	o_rvalid,
	i_rready,
	i_gci_mode,
	o_slot_valid,
	i_slot_ready,
	input wire logic [1:0] o_bresp,
	o_rresp,
	input wire logic [31:0] o_rdata,
	input wire logic [N_STREAMS*4-1:0] o_in_delay_half,
	input wire logic [N_STREAMS-1:0] o_latch_on_rise,
	input wire logic [3:0] o_slot_stream,
	o_source_stream_field,
	input wire logic [6:0] o_slot_chan,
	input wire logic [7:0] o_pc_byte
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);
	chk_write_answer: assert property (
		o_awready && i_awvalid && i_wvalid |=> o_bvalid && !o_awready)
		else $error("write not answered one cycle after acceptance");
	chk_bresp_hold: assert property (
		o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
		else $error("write response dropped before bready");
	chk_read_answer: assert property (
		o_arready && i_arvalid |=> o_rvalid)
		else $error("read not answered one cycle after acceptance");
	chk_rdata_hold: assert property (
		o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
		else $error("read data dropped before rready");
	chk_error_data: assert property (
		o_rvalid && o_rresp != RESP_OKAY |-> o_rresp == RESP_SLVERR && o_rdata == 32'h0)
		else $error("bad read response");
	chk_slot_hold: assert property (
		o_slot_valid && !i_slot_ready |=> o_slot_valid && $stable({o_slot_stream, o_slot_chan}))
		else $error("slot item changed while stalled");
	chk_pc_byte_top: assert property (
		o_slot_valid |-> o_pc_byte[7] == o_source_stream_field[0])
		else $error("output byte bit 7 differs from word bit 7");
	chk_edge_follow: assert property (
		$changed(i_gci_mode) |=> o_latch_on_rise == ~$past(o_latch_on_rise))
		else $error("latch edge did not follow interface mode");
	chk_delay_range: assert property (
		o_in_delay_half[3:0] <= 4'h9 && o_in_delay_half[N_STREAMS*4-1 -: 4] <= 4'h9)
		else $error("input delay beyond 4.5 periods");
endmodule // tsi_conn_engine_assertions

/* File: sim/tsi_slot_sink.sv */
// Far-side slot consumer; takes items, and when asked stalls one cycle in three.
// Assumes the engine clock; ready changes only after rising edges.
`timescale 1ns/1ps
module tsi_slot_sink (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic i_stall,
	output logic o_ready
);
	logic [1:0] phase_r;
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			phase_r <= 2'h0;
			o_ready <= 1'b0;
		end else begin
			phase_r <= (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
			o_ready <= !i_stall || phase_r != 2'h0;
		end
	end
endmodule // tsi_slot_sink

/* File: sim/test_tsi_conn_engine.sv */
// Self-checking bench for the connection engine over AXI4-Lite and the slot port.
// Assumes the engine, its package, the slot sink and the checker are compiled first.
`timescale 1ns/1ps
module test_tsi_conn_engine
	import tsi_conn_pkg::*;
;
	logic i_sys_clk, i_rstn, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, stall;
	logic i_frame_pulse_in, i_gci_mode, i_meas_valid, i_slot_ready, o_awready, o_wready;
	logic o_bvalid, o_arready, o_rvalid, o_control_channel_out, o_slot_valid, o_tx_drive_en;
	logic o_loop_back_bit, o_const_delay, o_processor_channel_bit;
	logic [ADDR_W-1:0] i_awaddr, i_araddr;
	logic [31:0] i_wdata, o_rdata;
	logic [3:0] i_wstrb, i_meas_half_delay, o_slot_stream, o_source_stream_field;
	logic [1:0] o_bresp, o_rresp;
	logic [63:0] o_in_delay_half;
	logic [15:0] o_latch_on_rise;
	logic [6:0] o_slot_chan, o_source_channel_field;
	logic [7:0] o_pc_byte;
	int failures, tests_run;
	tsi_conn_engine DUT (.*);
	tsi_slot_sink sink (.i_sys_clk, .i_rstn, .i_stall(stall), .o_ready(i_slot_ready));
	task automatic complete_run();
		$display("comparisons %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic give_up();
		failures++;
		complete_run();
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [13:0] cw(input int s, input int c);
		return 14'h2000 | 14'((s * 128 + c) * 4);
	endfunction
	task automatic wr(input logic [13:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		i_awaddr <= a;
		i_wdata <= d;
		n = 0;
		do begin
			@(posedge i_sys_clk);
			n++;
			if (o_awready) i_awvalid <= 1'b0;
			if (o_wready) i_wvalid <= 1'b0;
		end while (!o_bvalid && n < 50);
		if (!o_bvalid) give_up();
		cmp({30'h0, o_bresp}, {30'h0, er});
		i_bready <= 1'b0;
		@(posedge i_sys_clk);
	endtask
	task automatic rd(input logic [13:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		i_araddr <= a;
		n = 0;
		do begin
			@(posedge i_sys_clk);
			n++;
			if (o_arready) i_arvalid <= 1'b0;
		end while (!o_rvalid && n < 50);
		if (!o_rvalid) give_up();
		cmp(o_rdata, ed);
		cmp({30'h0, o_rresp}, {30'h0, er});
		i_rready <= 1'b0;
		@(posedge i_sys_clk);
	endtask
	task automatic slot(input logic [3:0] s, input logic [6:0] c);
		int n;
		n = 0;
		// Lets items built before the last write drain from the buffer first.
		repeat (4) @(posedge i_sys_clk);
		do begin
			@(posedge i_sys_clk);
			n++;
		end while (!(o_slot_valid && i_slot_ready && o_slot_stream == s && o_slot_chan == c)
			&& n < 8000);
		if (n >= 8000) give_up();
	endtask
	task automatic reset_values();
		rd(CTRL_OFS, {30'h0, RATE_RESET}, RESP_OKAY);
		rd(OFS_REG3_OFS, 32'h0, RESP_OKAY);
		rd(cw(2, 36), {16'h0, CM_RESET}, RESP_OKAY);
		rd(14'h0100, 32'h0, RESP_SLVERR);
		wr(14'h0100, 32'h1, RESP_SLVERR);
	endtask
	task automatic offsets();
		for (int h = 0; h < 10; h++) begin
			wr(OFS_REG0_OFS, 32'(h) << 4, RESP_OKAY);
			wr(OFS_REG3_OFS, 32'(h) << 12, RESP_OKAY);
			i_gci_mode <= h[1];
			repeat (2) @(posedge i_sys_clk);
			cmp(o_in_delay_half[7:4], h);
			cmp(o_in_delay_half[63:60], h);
			cmp(o_in_delay_half[3:0], 0);
			cmp(o_latch_on_rise[1], !h[0] ^ h[1]);
			rd(OFS_REG0_OFS, 32'(h) << 4, RESP_OKAY);
		end
	endtask
	task automatic measure();
		for (int h = 0; h < 10; h++) begin
			i_meas_half_delay <= 4'(h);
			i_meas_valid <= 1'b1;
			@(posedge i_sys_clk);
			i_meas_valid <= 1'b0;
			@(posedge i_sys_clk);
			rd(MEAS_OFS, {28'h0, !h[0], 3'(h / 2)}, RESP_OKAY);
		end
	endtask
	task automatic words();
		logic [15:0] w [3] = '{16'hA5C3, 16'h4B2A, 16'hE9D5};
		wr(OFS_REG0_OFS, 32'h0, RESP_OKAY);
		for (int i = 0; i < 3; i++) begin
			wr(cw(i * 5 + 1, i * 9 + 2), {16'h0, w[i]}, RESP_OKAY);
			slot(4'(i * 5 + 1), 7'(i * 9 + 2));
			cmp({o_loop_back_bit, o_const_delay, o_processor_channel_bit, o_tx_drive_en,
				o_source_stream_field, o_source_channel_field}, {w[i][15:13], w[i][11:0]});
			cmp(o_pc_byte, w[i][7:0]);
		end
	endtask
	task automatic rates();
		logic [6:0] m [3] = '{MASK_32, MASK_64, MASK_128};
		wr(cw(2, 3), 32'h0000_00FF, RESP_OKAY);
		for (int r = 0; r < 3; r++) begin
			wr(CTRL_OFS, 32'(r), RESP_OKAY);
			slot(4'h2, 7'h3);
			cmp(o_source_channel_field, m[r]);
			cmp(o_source_stream_field, 4'h1);
		end
	endtask
	task automatic control_bit();
		int hits;
		hits = 0;
		stall <= 1'b0;
		wr(cw(8, 10), 32'h0000_1000, RESP_OKAY);
		repeat (4096) begin
			@(posedge i_sys_clk);
			if (o_control_channel_out === 1'b1) begin
				hits++;
				cmp(o_slot_chan, 9);
			end
		end
		cmp(hits, 2);
	endtask
	task automatic frame_restart();
		int n;
		n = 0;
		i_frame_pulse_in <= 1'b1;
		@(posedge i_sys_clk);
		i_frame_pulse_in <= 1'b0;
		do begin
			@(posedge i_sys_clk);
			n++;
		end while (!(o_slot_valid && i_slot_ready && o_slot_stream == 4'h0 && o_slot_chan == 7'h0)
			&& n < 8);
		cmp(n < 8, 1);
	endtask
	initial begin
		i_sys_clk = 1'b0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end
	initial begin
		{i_rstn, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_meas_valid} = '0;
		{i_frame_pulse_in, i_gci_mode, i_awaddr, i_araddr, i_wdata, i_meas_half_delay} = '0;
		i_wstrb = 4'hF;
		stall = 1'b1;
		failures = 0;
		tests_run = 0;
		repeat (2) @(posedge i_sys_clk);
		i_rstn <= 1'b1;
		@(posedge i_sys_clk);
		reset_values();
		offsets();
		measure();
		words();
		rates();
		control_bit();
		frame_restart();
		complete_run();
	end
endmodule // test_tsi_conn_engine
bind tsi_conn_engine tsi_conn_engine_assertions #(.N_STREAMS(N_STREAMS)) chk (.*);
